/* sqc_pkg.sv */
// shared constants for the squelch and disable control block
package sqc_pkg;

  // ------------------------------------------------------------
  // serial bus address and register map
  // ------------------------------------------------------------
  localparam logic [4:0] ADDR_HI = 5'h12; // fixed upper address bits
  localparam logic [7:0] REG_SQ_A = 8'hC3;
  localparam logic [7:0] REG_SQ_B = 8'hE3;
  localparam logic [7:0] SQ_RST = 8'hFF;
  localparam logic [7:0] CFG_A_BASE = 8'h80;
  localparam logic [7:0] CFG_B_BASE = 8'hA0;
  localparam logic [7:0] CFG_RST = 8'h10;
  localparam logic [7:0] RD_UNMAPPED = 8'h00;

  // ------------------------------------------------------------
  // field positions
  // ------------------------------------------------------------
  localparam int EN_BIT = 4;
  localparam int SQ_LSB = 4;
  localparam int DIS_LSB = 0;
  localparam int BYTE_LAST = 7;

  // ------------------------------------------------------------
  // timing of the transmitter sequencer
  // ------------------------------------------------------------
  localparam int CLK_MHZ = 250;
  localparam int WAKE_NS = 1000;
  localparam int SQ_REC_NS = 20;
  localparam int CNT_W = 9;
  localparam logic [CNT_W-1:0] WAKE_CYC =
    CNT_W'((WAKE_NS * CLK_MHZ + 999) / 1000);
  localparam logic [CNT_W-1:0] SQ_CYC =
    CNT_W'((SQ_REC_NS * CLK_MHZ + 999) / 1000);

endpackage : sqc_pkg

/* sqc_tx_if.sv */
// request and status wires between the core and one lane sequencer
interface sqc_tx_if;
  logic pwr_req;
  logic cur_req;
  logic pwr_on;
  logic cur_on;
  modport core (output pwr_req, output cur_req, input pwr_on,
    input cur_on);
  modport seq (input pwr_req, input cur_req, output pwr_on,
    output cur_on);
endinterface : sqc_tx_if

/* sqc_sync.sv */
// two flip-flop level synchroniser
module sqc_sync #(
  parameter int W = 1
) (
  input wire logic clock,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);

  typedef struct packed {
    logic [W-1:0] meta;
    logic [W-1:0] q;
  } sqc_sync_t;

  sqc_sync_t s_r;
  sqc_sync_t s_nxt;

  // first stage feeds only the second stage
  always_comb begin
    s_nxt.meta = d;
    s_nxt.q = s_r.meta;
  end

  always_ff @(posedge clock) begin
    s_r <= s_nxt;
  end

  assign q = s_r.q;

endmodule : sqc_sync

/* sqc_tx_seq.sv */
// power and current sequencer of one transmitter lane
module sqc_tx_seq (
  input wire logic clock,
  input wire logic nrst,
  sqc_tx_if.seq tx
);

  typedef struct packed {
    logic pwr;
    logic cur;
    logic [sqc_pkg::CNT_W-1:0] cnt;
  } sqc_seq_t;

  sqc_seq_t s_r;
  sqc_seq_t s_nxt;

  // disable drops all at once, wake waits, squelch cuts current at once and its release waits briefly
  always_comb begin
    s_nxt = s_r;
    if (!tx.pwr_req) begin
      s_nxt = '0;
    end else if (!s_r.pwr) begin
      s_nxt.pwr = 1'b1;
      s_nxt.cnt = sqc_pkg::WAKE_CYC;
    end else if (!tx.cur_req) begin
      s_nxt.cur = 1'b0;
      if (s_r.cnt > sqc_pkg::SQ_CYC) begin
        s_nxt.cnt = s_r.cnt - 9'h001;
      end else begin
        s_nxt.cnt = sqc_pkg::SQ_CYC;
      end
    end else if (s_r.cnt != '0) begin
      s_nxt.cnt = s_r.cnt - 9'h001;
    end else begin
      s_nxt.cur = 1'b1;
    end
  end

  always_ff @(posedge clock) begin
    if (!nrst) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign tx.pwr_on = s_r.pwr;
  assign tx.cur_on = s_r.cur;

endmodule : sqc_tx_seq

/* sqc_top.sv */
// serial target with squelch, disable and lane enable registers

module sqc_top #(
  parameter int LANES_PER_PORT = 4
) (
  input wire logic clock,
  input wire logic nrst,
  input wire logic link_clk,
  input wire logic scl,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  input wire logic [1:0] addr_sel,
  output logic [2*LANES_PER_PORT-1:0] tx_pwr_on,
  output logic [2*LANES_PER_PORT-1:0] tx_cur_on
);

  localparam int NCFG = 2 * LANES_PER_PORT;

  // ------------------------------------------------------------
  // parameter check
  // ------------------------------------------------------------
  if (LANES_PER_PORT < 1 || LANES_PER_PORT > 16) begin : g_bad
    $error("lanes per port must lie between 1 and 16");
  end

  // ------------------------------------------------------------
  // state types
  // ------------------------------------------------------------
  typedef enum logic [3:0] {
    L_IDLE,
    L_ADDR,
    L_AACK,
    L_REG,
    L_RACK,
    L_WDAT,
    L_WACK,
    L_RDAT,
    L_MACK
  } sqc_lst_t;

  typedef struct packed {
    sqc_lst_t st;
    logic ps;
    logic pd;
    logic [3:0] cnt;
    logic [7:0] sh;
    logic rw;
    logic [7:0] ptr;
    logic oe;
    logic drv;
    logic wtog;
    logic rtog;
    logic aseen;
    logic [7:0] waddr;
    logic [7:0] wdata;
    logic [7:0] rdat;
  } sqc_link_t;

  typedef struct packed {
    logic [7:0] sq_a;
    logic [7:0] sq_b;
    logic [NCFG-1:0][7:0] cfg;
    logic wseen;
    logic rseen;
    logic atog;
    logic [7:0] rdata;
    logic [6:0] lhold;
    logic lrel;
  } sqc_core_t;

  sqc_link_t l_r;
  sqc_link_t l_nxt;
  sqc_core_t c_r;
  sqc_core_t c_nxt;

  logic scl_s;
  logic sda_s;
  logic [1:0] addr_s;
  logic lrst_n_s;
  logic atog_s;
  logic wtog_s;
  logic rtog_s;
  logic [NCFG-1:0] wr_hit;
  logic [NCFG-1:0] rd_hit;
  logic [NCFG-1:0] pwr_on;
  logic [NCFG-1:0] cur_on;

  // ------------------------------------------------------------
  // crossings
  // ------------------------------------------------------------

  // bus pins and address straps into the link domain
  sqc_sync #(.W(4)) u_pin_sync (
    .clock(link_clk),
    .d({addr_sel, scl, sda_in}),
    .q({addr_s, scl_s, sda_s})
  );

  // stretched reset and read answer toggle into the link domain
  sqc_sync #(.W(2)) u_lnk_sync (
    .clock(link_clk),
    .d({c_r.lrel, c_r.atog}),
    .q({lrst_n_s, atog_s})
  );

  // write and read request toggles into the core domain
  sqc_sync #(.W(2)) u_core_sync (
    .clock(clock),
    .d({l_r.wtog, l_r.rtog}),
    .q({wtog_s, rtog_s})
  );

  // ------------------------------------------------------------
  // link domain: serial target engine
  // ------------------------------------------------------------

  // bit, byte and acknowledge sequencing on sampled bus lines
  always_comb begin
    logic rise;
    logic fall;
    logic start;
    logic stop;
    logic [7:0] byte_in;
    rise = scl_s & ~l_r.ps;
    fall = ~scl_s & l_r.ps;
    start = scl_s & l_r.ps & l_r.pd & ~sda_s;
    stop = scl_s & l_r.ps & ~l_r.pd & sda_s;
    byte_in = {l_r.sh[6:0], sda_s};
    l_nxt = l_r;
    l_nxt.ps = scl_s;
    l_nxt.pd = sda_s;
    l_nxt.drv = 1'b0; // only ever pulls low
    // latch the read answer once its toggle arrives
    if (atog_s != l_r.aseen) begin
      l_nxt.aseen = atog_s;
      l_nxt.rdat = c_r.rdata;
    end
    if (start) begin
      l_nxt.st = L_ADDR;
      l_nxt.cnt = '0;
      l_nxt.oe = 1'b0;
    end else if (stop) begin
      l_nxt.st = L_IDLE;
      l_nxt.oe = 1'b0;
    end else begin
      case (l_r.st)
        // receive a byte msb first on rising clock
        L_ADDR, L_REG, L_WDAT: begin
          if (rise) begin
            l_nxt.sh = byte_in;
            l_nxt.cnt = l_r.cnt + 4'h1;
            if (l_r.cnt == 4'(sqc_pkg::BYTE_LAST)) begin
              l_nxt.cnt = '0;
              if (l_r.st == L_ADDR) begin
                if (byte_in[7:1] == {sqc_pkg::ADDR_HI, addr_s}) begin
                  l_nxt.st = L_AACK;
                  l_nxt.rw = byte_in[0];
                  if (byte_in[0]) begin
                    l_nxt.rtog = ~l_r.rtog;
                  end
                end else begin
                  l_nxt.st = L_IDLE;
                end
              end else if (l_r.st == L_REG) begin
                l_nxt.ptr = byte_in;
                l_nxt.st = L_RACK;
              end else begin
                l_nxt.waddr = l_r.ptr;
                l_nxt.wdata = byte_in;
                l_nxt.wtog = ~l_r.wtog;
                l_nxt.st = L_WACK;
              end
            end
          end
        end
        // drive ack low from one falling clock to the next
        L_AACK, L_RACK, L_WACK: begin
          if (fall) begin
            if (!l_r.oe) begin
              l_nxt.oe = 1'b1;
            end else begin
              l_nxt.oe = 1'b0;
              l_nxt.cnt = '0;
              if (l_r.st == L_AACK && l_r.rw) begin
                l_nxt.st = L_RDAT;
                l_nxt.sh = l_r.rdat;
                l_nxt.oe = ~l_r.rdat[7];
              end else if (l_r.st == L_AACK) begin
                l_nxt.st = L_REG;
              end else if (l_r.st == L_RACK) begin
                l_nxt.st = L_WDAT;
              end else begin
                l_nxt.st = L_IDLE;
              end
            end
          end
        end
        // shift read data out on falling clock
        L_RDAT: begin
          if (fall) begin
            if (l_r.cnt == 4'(sqc_pkg::BYTE_LAST)) begin
              l_nxt.oe = 1'b0;
              l_nxt.cnt = '0;
              l_nxt.st = L_MACK;
            end else begin
              l_nxt.cnt = l_r.cnt + 4'h1;
              l_nxt.sh = {l_r.sh[6:0], 1'b0};
              l_nxt.oe = ~l_r.sh[6];
            end
          end
        end
        // master ack repeats the byte, nack ends the read
        L_MACK: begin
          if (rise) begin
            if (sda_s) begin
              l_nxt.st = L_IDLE;
            end else begin
              l_nxt.cnt = 4'h8;
            end
          end else if (fall && l_r.cnt == 4'h8) begin
            l_nxt.st = L_RDAT;
            l_nxt.cnt = '0;
            l_nxt.sh = l_r.rdat;
            l_nxt.oe = ~l_r.rdat[7];
          end
        end
        default: begin
          l_nxt.oe = 1'b0;
        end
      endcase
    end
  end

  // link register, reset taken through the synchroniser it shares with the read answer toggle
  always_ff @(posedge link_clk) begin
    if (!lrst_n_s) begin
      l_r <= '0;
    end else begin
      l_r <= l_nxt;
    end
  end

  // ------------------------------------------------------------
  // core domain: register file
  // ------------------------------------------------------------

  // apply writes and answer reads named by the request toggles
  always_comb begin
    logic [7:0] rd;
    rd = sqc_pkg::RD_UNMAPPED;
    c_nxt = c_r;
    // a short core reset is stretched so the slow link clock sees it
    c_nxt.lhold = c_r.lhold + {6'h00, ~&c_r.lhold};
    c_nxt.lrel = &c_r.lhold;
    if (wtog_s != c_r.wseen) begin
      c_nxt.wseen = wtog_s;
      if (l_r.waddr == sqc_pkg::REG_SQ_A) begin
        c_nxt.sq_a = l_r.wdata;
      end
      if (l_r.waddr == sqc_pkg::REG_SQ_B) begin
        c_nxt.sq_b = l_r.wdata;
      end
      for (int i = 0; i < NCFG; i++) begin
        if (wr_hit[i]) begin
          c_nxt.cfg[i] = l_r.wdata;
        end
      end
    end
    // read mux on the held pointer
    if (l_r.ptr == sqc_pkg::REG_SQ_A) begin
      rd = c_r.sq_a;
    end else if (l_r.ptr == sqc_pkg::REG_SQ_B) begin
      rd = c_r.sq_b;
    end
    for (int i = 0; i < NCFG; i++) begin
      if (rd_hit[i]) begin
        rd = c_r.cfg[i];
      end
    end
    if (rtog_s != c_r.rseen) begin
      c_nxt.rseen = rtog_s;
      c_nxt.rdata = rd;
      c_nxt.atog = ~c_r.atog;
    end
  end

  // register file, all ports enabled after reset
  always_ff @(posedge clock) begin
    if (!nrst) begin
      c_r.sq_a <= sqc_pkg::SQ_RST;
      c_r.sq_b <= sqc_pkg::SQ_RST;
      c_r.cfg <= {NCFG{sqc_pkg::CFG_RST}};
      c_r.wseen <= 1'b0;
      c_r.rseen <= 1'b0;
      c_r.atog <= 1'b0;
      c_r.rdata <= sqc_pkg::RD_UNMAPPED;
      c_r.lhold <= 7'h00;
      c_r.lrel <= 1'b0;
    end else begin
      c_r <= c_nxt;
    end
  end

  // ------------------------------------------------------------
  // per lane decode and sequencing
  // ------------------------------------------------------------
  for (genvar i = 0; i < NCFG; i++) begin : g_lane
    localparam logic [7:0] OFF = (i < LANES_PER_PORT) ?
      sqc_pkg::CFG_A_BASE + 8'(i) :
      sqc_pkg::CFG_B_BASE + 8'(i - LANES_PER_PORT);
    logic [7:0] sqd;
    logic dis;
    logic sql;
    sqc_tx_if u_if ();

    assign wr_hit[i] = (l_r.waddr == OFF);
    assign rd_hit[i] = (l_r.ptr == OFF);
    // port register of this lane
    assign sqd = (i < LANES_PER_PORT) ? c_r.sq_a : c_r.sq_b;
    // only an all-zero nibble acts; disable wins
    assign dis = (sqd[sqc_pkg::DIS_LSB +: 4] == 4'h0) ||
      !c_r.cfg[i][sqc_pkg::EN_BIT];
    assign sql = (sqd[sqc_pkg::SQ_LSB +: 4] == 4'h0);
    assign u_if.pwr_req = !dis;
    assign u_if.cur_req = !dis && !sql;
    assign pwr_on[i] = u_if.pwr_on;
    assign cur_on[i] = u_if.cur_on;

    sqc_tx_seq u_seq (
      .clock(clock),
      .nrst(nrst),
      .tx(u_if)
    );
  end

  // ------------------------------------------------------------
  // outputs
  // ------------------------------------------------------------
  assign sda_oe = l_r.oe;
  assign sda_out = l_r.drv;
  assign tx_pwr_on = pwr_on;
  assign tx_cur_on = cur_on;

endmodule : sqc_top

/* sqc_i2c_mst.sv */
// bus controller model driving the serial clock and data pins
module sqc_i2c_mst (
  input wire logic clock,
  input wire logic sda_oe,
  output logic scl,
  output logic sda_in
);
  timeunit 1ns;
  timeprecision 1ps;
  logic m_sda;
  int q_lo;
  int q_hi;

  // open drain data wire with pull-up
  assign sda_in = m_sda & ~sda_oe;

  // idle bus; quick default rate keeps the run short, rated ones set later
  initial begin
    scl = 1'b1;
    m_sda = 1'b1;
    q_lo = 52;
    q_hi = 52;
  end

  // ----
  // bus cycles
  // ----
  task automatic wt(input int n);
    repeat (n) @(posedge clock);
  endtask : wt

  // start or stop; clock left high after stop
  task automatic bus_cond(input logic stp);
    wt(q_lo);
    m_sda <= ~stp;
    wt(q_lo);
    scl <= 1'b1;
    wt(q_hi);
    m_sda <= stp;
    wt(q_hi);
    if (!stp) begin
      scl <= 1'b0;
    end
  endtask : bus_cond

  // one bit, data moved only while the clock is low
  task automatic bit_io(input logic b, output logic r);
    wt(q_lo);
    m_sda <= b;
    wt(q_lo);
    scl <= 1'b1;
    wt(q_hi);
    r = sda_in;
    wt(q_hi);
    scl <= 1'b0;
  endtask : bit_io

  // one byte msb first, then the acknowledge bit
  task automatic xfer(input logic [7:0] d, input logic ak,
    output logic [7:0] q, output logic a);
    logic b;
    for (int i = 7; i >= 0; i--) begin
      bit_io(d[i], b);
      q = {q[6:0], b};
    end
    bit_io(ak, a);
  endtask : xfer
endmodule : sqc_i2c_mst

/* sqc_top_asserts.sv */
// pin-level assertions for the squelch control block
module sqc_top_asserts #(
  parameter int LANES_PER_PORT = 4
) (
  input wire logic clock,
  input wire logic nrst,
  input wire logic link_clk,
  input wire logic scl,
  input wire logic sda_in,
  input wire logic sda_out,
  input wire logic sda_oe,
  input wire logic [1:0] addr_sel,
  input wire logic [2*LANES_PER_PORT-1:0] tx_pwr_on,
  input wire logic [2*LANES_PER_PORT-1:0] tx_cur_on
);
  timeunit 1ns;
  timeprecision 1ps;
  localparam int L = LANES_PER_PORT;
  logic [8:0] wake_a_r;
  logic [8:0] wake_b_r;
  logic [3:0] low_r;
  logic [8:0] up_r;
  logic [1:0] ok_s_r = 2'b00;
  logic lk_ok;

  // core cycles since reset; link checks wait for the link reset
  always_ff @(posedge clock) begin
    up_r <= !nrst ? 9'h000 : up_r + {8'h00, ~&up_r};
  end

  // settled flag carried into the link domain
  always_ff @(posedge link_clk) begin
    ok_s_r <= {ok_s_r[0], &up_r};
  end
  assign lk_ok = ok_s_r[1];

  // ----
  // helper counters
  // ----
  // powered time of the first lane of each port
  always_ff @(posedge clock) begin
    wake_a_r <= (!nrst || !tx_pwr_on[0]) ? 9'h000 :
      wake_a_r + {8'h00, ~&wake_a_r};
    wake_b_r <= (!nrst || !tx_pwr_on[L]) ? 9'h000 :
      wake_b_r + {8'h00, ~&wake_b_r};
  end

  // link edges since the bus clock went low
  always_ff @(posedge link_clk) begin
    low_r <= (!nrst || scl) ? 4'h0 : low_r + {3'h0, ~&low_r};
  end

  // current cut while power stays on
  sequence s_sq_a;
    $fell(tx_cur_on[0]) ##1 tx_pwr_on[0];
  endsequence
  sequence s_sq_b;
    $fell(tx_cur_on[L]) ##1 tx_pwr_on[L];
  endsequence

  // ----
  // checks
  // ----
  a_sda_pull_only: assert property (@(posedge link_clk)
    disable iff (!lk_ok) !sda_out) else $error("data driven high");
  a_oe_after_fall: assert property (@(posedge link_clk)
    disable iff (!lk_ok) $changed(sda_oe) |-> low_r inside {[4'h1:4'h5]})
    else $error("data drive moved off clock low");
  a_oe_bounded: assert property (@(posedge link_clk)
    disable iff (!lk_ok) $rose(sda_oe) |-> ##[1:800] !sda_oe)
    else $error("data held low too long");
  a_cur_needs_pwr: assert property (@(posedge clock)
    disable iff (!nrst) (tx_cur_on & ~tx_pwr_on) == '0)
    else $error("current on an unpowered lane");
  a_wake_port_a: assert property (@(posedge clock)
    disable iff (!nrst) $rose(tx_cur_on[0]) |-> wake_a_r >= 9'h0F8)
    else $error("port a output before wake time");
  a_wake_port_b: assert property (@(posedge clock)
    disable iff (!nrst) $rose(tx_cur_on[L]) |-> wake_b_r >= 9'h0F8)
    else $error("port b output before wake time");
  a_squelch_port_a: assert property (@(posedge clock)
    disable iff (!nrst) s_sq_a |-> tx_cur_on[L-1:0] == '0)
    else $error("port a squelch not whole port");
  a_squelch_port_b: assert property (@(posedge clock)
    disable iff (!nrst) s_sq_b |-> tx_cur_on[2*L-1:L] == '0)
    else $error("port b squelch not whole port");
endmodule : sqc_top_asserts

bind sqc_top sqc_top_asserts #(.LANES_PER_PORT(LANES_PER_PORT))
  sqc_top_asserts_inst (.clock(clock), .nrst(nrst), .link_clk(link_clk),
  .scl(scl), .sda_in(sda_in), .sda_out(sda_out), .sda_oe(sda_oe),
  .addr_sel(addr_sel), .tx_pwr_on(tx_pwr_on), .tx_cur_on(tx_cur_on));

/* tb_top.sv */
// self-checking bench for the squelch and disable control block
`define CHK(g, e) begin \
  n_compared++; \
  if ((g) !== (e)) begin \
    fails++; \
    $display("MISMATCH t=%0t got %h exp %h", $time, g, e); \
  end \
end

module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic clock;
  logic nrst;
  logic link_clk;
  logic scl;
  logic sda_in;
  logic sda_out;
  logic sda_oe;
  logic [1:0] addr_sel;
  logic [7:0] tx_pwr_on;
  logic [7:0] tx_cur_on;
  logic [6:0] dev;
  int fails;
  int n_compared;

  assign dev = {sqc_pkg::ADDR_HI, addr_sel};

  sqc_top #(.LANES_PER_PORT(4)) sqc_top_inst (.clock(clock), .nrst(nrst),
    .link_clk(link_clk), .scl(scl), .sda_in(sda_in), .sda_out(sda_out),
    .sda_oe(sda_oe), .addr_sel(addr_sel), .tx_pwr_on(tx_pwr_on),
    .tx_cur_on(tx_cur_on));

  sqc_i2c_mst sqc_i2c_mst_inst (.clock(clock), .sda_oe(sda_oe), .scl(scl),
    .sda_in(sda_in));

  // ----
  // clocks and run control
  // ----
  initial begin
    clock = 1'b0;
    forever #2 clock = ~clock;
  end

  // link clock, phase unrelated to the core clock
  initial begin
    link_clk = 1'b0;
    #37;
    forever #62.5 link_clk = ~link_clk;
  end

  task automatic end_sim();
    $display("compared %0d mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : end_sim

  // cut a hang well past the expected run of about 400 us
  initial begin
    #480_000;
    fails++;
    end_sim();
  end

  // ----
  // bus tasks
  // ----
  // start, address for writing, then the register pointer
  task automatic ptr_wr(input logic [7:0] ra);
    logic [7:0] q;
    logic a;
    sqc_i2c_mst_inst.bus_cond(1'b0);
    sqc_i2c_mst_inst.xfer({dev, 1'b0}, 1'b1, q, a);
    `CHK(a, 1'b0)
    sqc_i2c_mst_inst.xfer(ra, 1'b1, q, a);
    `CHK(a, 1'b0)
  endtask : ptr_wr

  // full write, then lane power and current compared
  task automatic wr_chk(input logic [7:0] ra, input logic [7:0] d,
    input logic [7:0] pwr, input logic [7:0] cur);
    logic [7:0] q;
    logic a;
    ptr_wr(ra);
    sqc_i2c_mst_inst.xfer(d, 1'b1, q, a);
    `CHK(a, 1'b0)
    sqc_i2c_mst_inst.bus_cond(1'b1);
    `CHK(tx_pwr_on, pwr)
    `CHK(tx_cur_on, cur)
  endtask : wr_chk

  // read at the held pointer, byte refused at the end
  task automatic rd_held(input logic [7:0] e);
    logic [7:0] q;
    logic a;
    sqc_i2c_mst_inst.bus_cond(1'b0);
    sqc_i2c_mst_inst.xfer({dev, 1'b1}, 1'b1, q, a);
    `CHK(a, 1'b0)
    sqc_i2c_mst_inst.xfer(8'hFF, 1'b1, q, a);
    `CHK(q, e)
    sqc_i2c_mst_inst.bus_cond(1'b1);
  endtask : rd_held

  // ----
  // test sequence
  // ----
  initial begin
    logic [7:0] q;
    logic a;
    nrst = 1'b0;
    addr_sel = 2'b11;
    fails = 0;
    n_compared = 0;
    repeat (16) @(posedge clock);
    nrst <= 1'b1;
    repeat (400) @(posedge clock);
    `CHK(tx_pwr_on, 8'hFF)
    `CHK(tx_cur_on, 8'hFF)
    ptr_wr(sqc_pkg::REG_SQ_A);
    rd_held(sqc_pkg::SQ_RST);
    wr_chk(sqc_pkg::REG_SQ_A, 8'h0F, 8'hFF, 8'hF0);
    wr_chk(sqc_pkg::REG_SQ_A, 8'hF0, 8'hF0, 8'hF0);
    wr_chk(sqc_pkg::REG_SQ_A, 8'h00, 8'hF0, 8'hF0);
    wr_chk(sqc_pkg::REG_SQ_A, 8'h7E, 8'hFF, 8'hFF);
    rd_held(8'h7E);
    wr_chk(sqc_pkg::REG_SQ_B, 8'h0F, 8'hFF, 8'h0F);
    wr_chk(sqc_pkg::CFG_A_BASE + 8'h01, 8'h00, 8'hFD, 8'h0D);
    wr_chk(sqc_pkg::CFG_A_BASE + 8'h01, sqc_pkg::CFG_RST, 8'hFF,
      8'h0F);
    wr_chk(sqc_pkg::REG_SQ_B, sqc_pkg::SQ_RST, 8'hFF, 8'hFF);
    // foreign address left unanswered
    sqc_i2c_mst_inst.bus_cond(1'b0);
    sqc_i2c_mst_inst.xfer({dev ^ 7'h01, 1'b0}, 1'b1, q, a);
    `CHK(a, 1'b1)
    sqc_i2c_mst_inst.bus_cond(1'b1);
    // new pin address, standard mode rate, address byte only
    addr_sel <= 2'b10;
    sqc_i2c_mst_inst.q_lo = 625;
    sqc_i2c_mst_inst.q_hi = 625;
    sqc_i2c_mst_inst.bus_cond(1'b0);
    sqc_i2c_mst_inst.xfer({dev, 1'b0}, 1'b1, q, a);
    `CHK(a, 1'b0)
    sqc_i2c_mst_inst.bus_cond(1'b1);
    // fast mode rate read at the held pointer
    sqc_i2c_mst_inst.q_lo = 170;
    sqc_i2c_mst_inst.q_hi = 143;
    rd_held(sqc_pkg::SQ_RST);
    end_sim();
  end
endmodule : tb_top
